// file: shared/bkl_regs_map.svh
// Register map constants for the backlight control and status bank
// ==========================================
// Contract
// [RQ1] Control bit 0 selects standby when clear, active when set; resets zero.
// [RQ2] Control bit 1 enables boost converter; resets zero.
// [RQ3] Control bit 2 selects adaptive boost when set, manual when clear; resets one.
// [RQ4] Control bit 3 drives boost loader enable; resets zero.
// [RQ5] Control bit 4 picks second sensor input when set, first when clear.
// [RQ6] Control bit 5 picks red LED voltage as temperature reference when set.
// [RQ7] 12-bit result readable: upper nibble at 0x08, low byte at 0x09.
// [RQ8] Three 8-bit colour gain multipliers, reset 0x80 meaning unity.
// [RQ9] Memory control bit 7 reads ready flag, one after reset.
// [RQ10] Writing one to memory control bit 6 starts an erase.
// [RQ11] Writing one to memory control bit 5 starts programming.
// [RQ12] Memory control bit 4 shows load to working memory, read only.
// [RQ13] Page field bits 1:0 picks one 32-location window of memory.
// [RQ14] Manual boost uses a 5-bit voltage code, 1 V per step.
// [RQ15] Busy sequence holds ready low; finish clears start bit, sets ready.
`ifndef BKL_REGS_MAP_SVH
`define BKL_REGS_MAP_SVH
`define BKL_ADDR_BOOST 8'h05
`define BKL_ADDR_CTRL 8'h06
`define BKL_ADDR_RES_HI 8'h08
`define BKL_ADDR_RES_LO 8'h09
`define BKL_ADDR_GAIN_R 8'h0a
`define BKL_ADDR_GAIN_G 8'h0b
`define BKL_ADDR_GAIN_B 8'h0c
`define BKL_ADDR_NVM 8'h0d
`define BKL_ADDR_IRQ_STAT 8'h10
`define BKL_ADDR_IRQ_MASK 8'h11
`define BKL_CTRL_RESET 8'h04
`define BKL_CTRL_WMASK 8'h3f
`define BKL_GAIN_RESET 8'h80
`define BKL_BOOST_RESET 8'h00
`define BKL_BOOST_WMASK 8'h1f
`define BKL_NVM_READY_BIT 7
`define BKL_NVM_ERASE_BIT 6
`define BKL_NVM_PROG_BIT 5
`define BKL_NVM_LOAD_BIT 4
`define BKL_IRQ_DONE_BIT 0
`define BKL_IRQ_RESULT_BIT 1
`endif

// file: shared/bkl_pkg.sv
// Types shared by the backlight register bank
`default_nettype none
package bkl_pkg;
    typedef enum logic [1:0] {BKL_IDLE, BKL_ERASE, BKL_PROG, BKL_LOAD} bkl_nvm_state_e;
endpackage
`default_nettype wire

// file: rtl/bkl_regs.sv
// Backlight control and status register bank with memory sequencer handshake
`include "bkl_regs_map.svh"
`default_nettype none
module bkl_regs
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [11:0] sensor_result,
    input wire logic sensor_result_valid,
    input wire logic nvm_op_done,
    input wire logic nvm_load_busy,
    output logic device_active,
    output logic boost_enable,
    output logic boost_adaptive,
    output logic boost_loader_enable,
    output logic [4:0] boost_voltage_code,
    output logic sensor_input_second,
    output logic temperature_reference_pick,
    output logic [7:0] red_gain,
    output logic [7:0] green_gain,
    output logic [7:0] blue_gain,
    output logic nvm_erase_start,
    output logic nvm_program_start,
    output logic nvm_load_to_sram,
    output logic nvm_ready_flag,
    output logic [1:0] nvm_page_select,
    output logic irq
);
    // ==========================================
    // Storage
    logic [7:0] ctrl_reg;
    logic [4:0] boost_reg;
    logic [7:0] gain_r_reg;
    logic [7:0] gain_g_reg;
    logic [7:0] gain_b_reg;
    logic [11:0] result_reg;
    logic [1:0] page_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic [1:0] irq_set;
    logic load_reg;
    logic done_seen;
    bkl_pkg::bkl_nvm_state_e nvm_state_reg;
    logic nvm_idle;

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = reg_wr && (reg_addr == a);
    endfunction

    assign nvm_idle = (nvm_state_reg == bkl_pkg::BKL_IDLE);

    // ==========================================
    // Control and gain registers
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            ctrl_reg <= `BKL_CTRL_RESET;
        else if (wr_hit(`BKL_ADDR_CTRL))
            ctrl_reg <= reg_wdata & `BKL_CTRL_WMASK;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            boost_reg <= 5'h00;
        else if (wr_hit(`BKL_ADDR_BOOST))
            boost_reg <= reg_wdata[4:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            gain_r_reg <= `BKL_GAIN_RESET;
            gain_g_reg <= `BKL_GAIN_RESET;
            gain_b_reg <= `BKL_GAIN_RESET;
        end
        else
        begin
            if (wr_hit(`BKL_ADDR_GAIN_R))
                gain_r_reg <= reg_wdata; // [RQ8]
            if (wr_hit(`BKL_ADDR_GAIN_G))
                gain_g_reg <= reg_wdata; // [RQ8]
            if (wr_hit(`BKL_ADDR_GAIN_B))
                gain_b_reg <= reg_wdata; // [RQ8]
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            result_reg <= 12'h000;
        else if (sensor_result_valid)
            result_reg <= sensor_result; // [RQ7]
    end

    assign device_active = ctrl_reg[0]; // [RQ1]
    assign boost_enable = ctrl_reg[1]; // [RQ2]
    assign boost_adaptive = ctrl_reg[2]; // [RQ3]
    assign boost_loader_enable = ctrl_reg[3]; // [RQ4]
    assign sensor_input_second = ctrl_reg[4]; // [RQ5]
    assign temperature_reference_pick = ctrl_reg[5]; // [RQ6]
    // Code only meaningful in manual mode; the adaptive loop ignores it
    assign boost_voltage_code = boost_reg; // [RQ14]
    assign red_gain = gain_r_reg;
    assign green_gain = gain_g_reg;
    assign blue_gain = gain_b_reg;

    // ==========================================
    // Memory sequencer handshake
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            page_reg <= 2'h0;
        else if (wr_hit(`BKL_ADDR_NVM))
            page_reg <= reg_wdata[1:0]; // [RQ13]
    end

    // Erase wins over program if both are written at once; starts are ignored while busy
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            nvm_state_reg <= bkl_pkg::BKL_IDLE;
        else
        begin
            case (nvm_state_reg)
                bkl_pkg::BKL_IDLE:
                begin
                    if (wr_hit(`BKL_ADDR_NVM) && reg_wdata[`BKL_NVM_ERASE_BIT])
                        nvm_state_reg <= bkl_pkg::BKL_ERASE; // [RQ10]
                    else if (wr_hit(`BKL_ADDR_NVM) && reg_wdata[`BKL_NVM_PROG_BIT])
                        nvm_state_reg <= bkl_pkg::BKL_PROG; // [RQ11]
                    else if (nvm_load_busy)
                        nvm_state_reg <= bkl_pkg::BKL_LOAD;
                end
                bkl_pkg::BKL_ERASE, bkl_pkg::BKL_PROG:
                begin
                    if (nvm_op_done)
                        nvm_state_reg <= bkl_pkg::BKL_IDLE; // [RQ15]
                end
                bkl_pkg::BKL_LOAD:
                begin
                    if (!nvm_load_busy)
                        nvm_state_reg <= bkl_pkg::BKL_IDLE; // [RQ15]
                end
                default:
                    nvm_state_reg <= bkl_pkg::BKL_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            load_reg <= 1'b0;
        else
            load_reg <= nvm_load_busy; // [RQ12]
    end

    assign nvm_erase_start = (nvm_state_reg == bkl_pkg::BKL_ERASE);
    assign nvm_program_start = (nvm_state_reg == bkl_pkg::BKL_PROG);
    assign nvm_load_to_sram = load_reg;
    assign nvm_ready_flag = nvm_idle; // [RQ9] [RQ15]
    assign nvm_page_select = page_reg;

    // ==========================================
    // Interrupts: sequence done and new sensor result
    assign done_seen = !nvm_idle && ((nvm_state_reg == bkl_pkg::BKL_LOAD) ? !nvm_load_busy
                                                                          : nvm_op_done);
    assign irq_set = {sensor_result_valid, done_seen};

    // Set beats a write-one clear in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            irq_stat_reg <= 2'h0;
        else if (wr_hit(`BKL_ADDR_IRQ_STAT))
            irq_stat_reg <= (irq_stat_reg & ~reg_wdata[1:0]) | irq_set;
        else
            irq_stat_reg <= irq_stat_reg | irq_set;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            irq_mask_reg <= 2'h0;
        else if (wr_hit(`BKL_ADDR_IRQ_MASK))
            irq_mask_reg <= reg_wdata[1:0];
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ==========================================
    // Read port, data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `BKL_ADDR_BOOST: reg_rdata <= {3'h0, boost_reg};
                `BKL_ADDR_CTRL: reg_rdata <= ctrl_reg;
                `BKL_ADDR_RES_HI: reg_rdata <= {4'h0, result_reg[11:8]}; // [RQ7]
                `BKL_ADDR_RES_LO: reg_rdata <= result_reg[7:0]; // [RQ7]
                `BKL_ADDR_GAIN_R: reg_rdata <= gain_r_reg;
                `BKL_ADDR_GAIN_G: reg_rdata <= gain_g_reg;
                `BKL_ADDR_GAIN_B: reg_rdata <= gain_b_reg;
                `BKL_ADDR_NVM: reg_rdata <= {nvm_ready_flag, nvm_erase_start, nvm_program_start,
                                             load_reg, 2'h0, page_reg};
                `BKL_ADDR_IRQ_STAT: reg_rdata <= {6'h00, irq_stat_reg};
                `BKL_ADDR_IRQ_MASK: reg_rdata <= {6'h00, irq_mask_reg};
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end
endmodule
`default_nettype wire

// file: sim/bkl_regs_chk.sv
// Port checker for the backlight register bank
`default_nettype none
module bkl_regs_chk
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic nvm_op_done,
    input wire logic nvm_load_busy,
    input wire logic device_active,
    input wire logic boost_enable,
    input wire logic [7:0] red_gain,
    input wire logic nvm_erase_start,
    input wire logic nvm_program_start,
    input wire logic nvm_load_to_sram,
    input wire logic nvm_ready_flag,
    input wire logic [1:0] nvm_page_select
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire nvw = reg_wr && reg_addr == 8'h0d;
    wire idle = nvm_ready_flag && !nvm_load_busy;
    property p_ctrl; reg_wr && reg_addr == 8'h06 |=> device_active == $past(reg_wdata[0])
        && boost_enable == $past(reg_wdata[1]); endproperty
    a_ctrl: assert property (p_ctrl) else $error("control bits not applied");
    property p_hi; reg_rd && reg_addr == 8'h08 |=> reg_rdata[7:4] == 4'h0; endproperty
    a_hi: assert property (p_hi) else $error("result upper bits not zero");
    property p_gain; reg_wr && reg_addr == 8'h0a |=> red_gain == $past(reg_wdata); endproperty
    a_gain: assert property (p_gain) else $error("red gain not written");
    property p_ready; $rose(reset_n) |-> nvm_ready_flag; endproperty
    a_ready: assert property (p_ready) else $error("ready low after reset");
    property p_erase; nvw && reg_wdata[6] && idle |=> nvm_erase_start [*2]; endproperty
    a_erase: assert property (p_erase) else $error("erase did not start");
    property p_prog; nvw && reg_wdata[6:5] == 2'b01 && idle |=> nvm_program_start; endproperty
    a_prog: assert property (p_prog) else $error("program did not start");
    property p_load; nvm_load_to_sram == $past(nvm_load_busy); endproperty
    a_load: assert property (p_load) else $error("load flag does not follow");
    property p_page; nvw |=> nvm_page_select == $past(reg_wdata[1:0]); endproperty
    a_page: assert property (p_page) else $error("page not written");
    property p_busy; nvm_erase_start || nvm_program_start |-> !nvm_ready_flag; endproperty
    a_busy: assert property (p_busy) else $error("ready high while busy");
    property p_done; nvm_erase_start && nvm_op_done |=> !nvm_erase_start
        && nvm_ready_flag; endproperty
    a_done: assert property (p_done) else $error("erase did not finish");
endmodule
bind bkl_regs bkl_regs_chk i_chk (.*);
`default_nettype wire

// file: sim/bkl_nvm_model.sv
// Behavioural memory engine answering erase and program sequences
`default_nettype none
module bkl_nvm_model
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic nvm_erase_start,
    input wire logic nvm_program_start,
    input wire logic slow,
    output logic nvm_op_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_reg;
    // One done pulse per sequence, after a short or a long run
    always_ff @(posedge core_clk)
    begin
        if (!reset_n || !(nvm_erase_start || nvm_program_start) || nvm_op_done)
        begin
            cnt_reg <= 4'h0;
            nvm_op_done <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_reg + 4'h1;
            nvm_op_done <= cnt_reg == (slow ? 4'h9 : 4'h2);
        end
    end
endmodule
`default_nettype wire

// file: sim/test_bkl_regs.sv
// Self-checking bench for the backlight register bank
`default_nettype none
module test_bkl_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [11:0] sensor_result = 12'h000;
    logic sensor_result_valid = 1'b0;
    logic nvm_load_busy = 1'b0;
    logic slow = 1'b0;
    logic [7:0] reg_rdata, red_gain, green_gain, blue_gain, v, d;
    logic [4:0] boost_voltage_code;
    logic [1:0] nvm_page_select;
    logic device_active, boost_enable, boost_adaptive, boost_loader_enable, irq;
    logic sensor_input_second, temperature_reference_pick, nvm_op_done;
    logic nvm_erase_start, nvm_program_start, nvm_load_to_sram, nvm_ready_flag;
    logic [11:0] r;
    logic [7:0] addrs [7] = '{8'h06, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h08, 8'h3f};
    logic [7:0] rstv [7] = '{8'h04, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00};
    integer errors = 0, n_checks = 0, seed = 48727, i, k;
    bkl_regs i_dut (.*);
    bkl_nvm_model i_nvm (.core_clk, .reset_n, .nvm_erase_start, .nvm_program_start,
        .slow, .nvm_op_done);
    initial
    forever #20 core_clk = ~core_clk;
    // ====================
    // Bus and compare tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] x,
        output logic [7:0] q);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ====================
    // Main sequence
    initial
    begin
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        for (i = 0; i < 7; i++)
        begin
            bus(1'b0, addrs[i], 8'h00, d);
            chk(d, rstv[i]);
        end
        for (i = 0; i < 6; i++)
        begin
            v = $random(seed);
            if (i < 2) v = i ? 8'hff : 8'h00;
            bus(1'b1, 8'h06, v, d);
            chk({temperature_reference_pick, sensor_input_second, boost_loader_enable,
                boost_adaptive, boost_enable, device_active}, v[5:0]);
            bus(1'b0, 8'h06, 8'h00, d);
            chk(d, v & 8'h3f);
            v = $random(seed);
            bus(1'b1, 8'h0a + i[7:0] % 3, v, d);
            bus(1'b0, 8'h0a + i[7:0] % 3, 8'h00, d);
            chk(d, v);
        end
        bus(1'b1, 8'h05, 8'h14, d);
        chk(boost_voltage_code, 5'h14);
        r = $random(seed);
        @(posedge core_clk);
        sensor_result <= r;
        sensor_result_valid <= 1'b1;
        @(posedge core_clk);
        sensor_result_valid <= 1'b0;
        bus(1'b0, 8'h08, 8'h00, d);
        chk({d, irq}, {4'h0, r[11:8], 1'b0});
        bus(1'b1, 8'h11, 8'h03, d);
        bus(1'b0, 8'h09, 8'h00, d);
        chk({d, irq}, {r[7:0], 1'b1});
        bus(1'b1, 8'h10, 8'h02, d);
        chk(irq, 1'b0);
        for (i = 0; i < 2; i++)
        begin
            slow <= i[0];
            bus(1'b1, 8'h0d, i ? 8'h23 : 8'h41, d);
            chk({nvm_erase_start, nvm_program_start, nvm_ready_flag}, i ? 2 : 4);
            bus(1'b1, 8'h0d, i ? 8'h63 : 8'h61, d);
            chk({nvm_erase_start, nvm_program_start, nvm_ready_flag}, i ? 2 : 4);
            chk(nvm_page_select, i ? 2'h3 : 2'h1);
            for (k = 0; k < 30 && !nvm_ready_flag; k++)
                @(posedge core_clk) #1;
            chk({nvm_erase_start, nvm_program_start, irq}, 3'b001);
            bus(1'b1, 8'h10, 8'h01, d);
            bus(1'b0, 8'h0d, 8'h00, d);
            chk(d, i ? 8'h83 : 8'h81);
        end
        @(posedge core_clk);
        nvm_load_busy <= 1'b1;
        bus(1'b0, 8'h0d, 8'h00, d);
        chk(d[7:4], 4'h1);
        chk(nvm_load_to_sram, 1'b1);
        @(posedge core_clk);
        nvm_load_busy <= 1'b0;
        repeat (2) @(posedge core_clk);
        bus(1'b0, 8'h0d, 8'h00, d);
        chk(d, 8'h83);
        print_verdict();
    end
    initial
    begin
        repeat (4000) @(posedge core_clk);
        errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
